// >>> src/user_card_map.svh
// Register offsets, field positions, reset values and timing counts
// for the user card slot registers.
// Assumes the includer uses the types of user_card_pkg alongside.
`ifndef USER_CARD_MAP_SVH
`define USER_CARD_MAP_SVH

`define UC_STATUS_ADDR 8'h00
`define UC_SETTINGS_ADDR 8'h01
`define UC_CLOCK_ADDR 8'h02

`define ST_POWERED_BIT 7
`define ST_TOO_SOON_BIT 6
`define ST_MISSING_BIT 5
`define ST_OVERCURRENT_BIT 4
`define ST_INT_OSC_BIT 3
`define ST_INSERT_CHG_BIT 2
`define ST_PRESENT_BIT 1
`define ST_RAMP_FAULT_BIT 0

`define SET_SUPPLY_HI 7
`define SET_SUPPLY_LO 6
`define SET_CONNECT_BIT 5
`define SET_WARM_BIT 3
`define SET_POLARITY_BIT 2
`define SET_ACTIVATE_BIT 0

`define CLK_INT_OSC_BIT 7
`define CLK_LOW_BIT 6
`define CLK_HIGH_BIT 5
`define CLK_DIV_HI 4
`define CLK_DIV_LO 2

`define SUPPLY_RESET 2'b01
`define CONNECT_RESET 1'b1
`define WARM_RESET 1'b0
`define POLARITY_RESET 1'b0
`define ACTIVATE_RESET 1'b0
`define INT_OSC_RESET 1'b0
`define FORCE_LOW_RESET 1'b0
`define FORCE_HIGH_RESET 1'b0
`define DIV_RESET 3'b011

`define DIV_CODE_BY1 3'b000
`define DIV_CODE_BY2 3'b001
`define DIV_CODE_BY4 3'b010
`define DIV_CODE_BY5 3'b011

`define MCLK_KHZ 125000
`define INT_OSC_KHZ 1200
`define INT_OSC_HALF_CYCLES (`MCLK_KHZ / (2 * `INT_OSC_KHZ))
`define DATA_BLANK_CYCLES 3'd4

`endif

// >>> src/user_card_pkg.sv
// Types shared by the user card slot register bank and its clock block.
// Assumes nothing beyond a SystemVerilog compiler.
package user_card_pkg;

	typedef enum logic [1:0] {
		MODE_ASYNC,
		MODE_SYNC1,
		MODE_SYNC2,
		MODE_MANUAL
	} op_mode_type;

	typedef enum logic [1:0] {
		SUPPLY_1V8,
		SUPPLY_3V0,
		SUPPLY_5V0
	} supply_level_type;

	typedef struct packed {
		logic internalOscSelect;
		logic clockForceLow;
		logic clockForceHigh;
		logic [2:0] clockDividerCode;
	} clock_cfg_type;

	typedef struct packed {
		logic answerTooSoon;
		logic answerMissing;
		logic overcurrent;
		logic supplyRampFault;
	} card_events_type;

	typedef struct packed {
		logic activateStart;
		logic deactivateStart;
		logic warmResetRequest;
	} seq_ctrl_type;

endpackage

// >>> src/card_clock_gen.sv
// Card clock generator: divider, internal oscillator and level forcing.
// Assumes mclk is the input clock and rstSyncN is already synchronised.
`include "user_card_map.svh"

module card_clock_gen (
	input wire logic mclk,
	input wire logic rstSyncN,
	input wire user_card_pkg::clock_cfg_type cfg,
	input wire logic syncMode,
	input wire logic syncClockEnable,
	output logic cardClockOut,
	output logic internalOscActive
);

	localparam logic [5:0] OSC_HALF = 6'(`INT_OSC_HALF_CYCLES);

	logic [3:0] divCnt_r;
	logic [3:0] divCnt_nxt;
	logic [3:0] factor;
	logic [5:0] oscCnt_r;
	logic oscOut_r;
	logic level_r;
	logic level_nxt;
	logic useRaw;

	function automatic logic [3:0] divFactor(input logic [2:0] code);
		case (code)
			`DIV_CODE_BY1: divFactor = 4'h1;
			`DIV_CODE_BY2: divFactor = 4'h2;
			`DIV_CODE_BY4: divFactor = 4'h4;
			`DIV_CODE_BY5: divFactor = 4'h5;
			default: divFactor = 4'h8;
		endcase
	endfunction

	assign factor = divFactor(cfg.clockDividerCode);
	assign divCnt_nxt = (divCnt_r >= factor - 4'h1) ? 4'h0 : divCnt_r + 4'h1;

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			divCnt_r <= 4'h0;
		else
			divCnt_r <= divCnt_nxt;
	end

	// Free running so a switch to it needs no restart
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			oscCnt_r <= 6'h00;
			oscOut_r <= 1'b0;
		end
		else if (oscCnt_r >= OSC_HALF - 6'h01)
		begin
			oscCnt_r <= 6'h00;
			oscOut_r <= ~oscOut_r;
		end
		else
			oscCnt_r <= oscCnt_r + 6'h01;
	end

	always_comb
	begin
		level_nxt = 1'b0;
		if (syncMode)
		begin
			if (cfg.clockForceLow)
				level_nxt = 1'b0;
			else if (cfg.clockForceHigh && !syncClockEnable)
				level_nxt = 1'b1;
			else
				level_nxt = 1'b0;
		end
		else if (cfg.internalOscSelect)
			level_nxt = oscOut_r;
		else if (cfg.clockForceLow)
			level_nxt = 1'b0;
		else if (cfg.clockForceHigh)
			level_nxt = 1'b1;
		else
			level_nxt = divCnt_nxt < (factor >> 1);
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			level_r <= 1'b0;
		else
			level_r <= level_nxt;
	end

	// Undivided paths cannot come from a flop, so mclk is muxed out
	always_comb
	begin
		useRaw = 1'b0;
		if (!rstSyncN)
			useRaw = 1'b0;
		else if (syncMode)
			useRaw = syncClockEnable && !cfg.clockForceLow;
		else
			useRaw = !cfg.internalOscSelect && !cfg.clockForceLow &&
				!cfg.clockForceHigh && (factor == 4'h1);
	end

	assign cardClockOut = useRaw ? mclk : level_r;
	assign internalOscActive = !syncMode && cfg.internalOscSelect;

endmodule

// >>> src/user_card_interface_regs.sv
// User card slot registers: status, interface settings, clock settings.
// Assumes the serial control bus front end presents one-cycle read and
// write strobes with an 8-bit address, and that event inputs come from
// logic on mclk. Presence and data line pins are asynchronous.
`include "user_card_map.svh"

module user_card_interface_regs (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire user_card_pkg::op_mode_type opMode,
	input wire logic syncClockEnable,
	input wire logic slotPoweredFlag,
	input wire user_card_pkg::card_events_type cardEvents,
	input wire logic warmResetStarted,
	input wire logic autoDeactivate,
	input wire logic presencePin,
	input wire logic hostDataLineIn,
	output logic hostDataLineOut,
	output logic hostDataLineOen_n,
	input wire logic cardDataLineIn,
	output logic cardDataLineOut,
	output logic cardDataLineOen_n,
	output logic cardClockOut,
	output user_card_pkg::supply_level_type cardSupplySelect,
	output user_card_pkg::seq_ctrl_type seqCtrl,
	output logic slotIrqSummary
);

	logic rstMeta_r;
	logic rstSyncN;
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sync3_r;
	logic [2:0] filt_r;
	logic presenceSeen_r;
	logic presenceReady_r;
	logic cardPresentFlag;
	logic insertEdge;
	logic asyncMode;
	logic syncMode;
	logic statusRead;
	logic settingsWrite;
	logic clockWrite;
	logic answerTooSoonFlag;
	logic answerMissingFlag;
	logic overcurrentFlag;
	logic insertChangeFlag;
	logic supplyRampFaultFlag;
	logic internalOscActiveFlag;
	logic [1:0] cardSupplySelect_r;
	logic dataLineConnect_r;
	logic warmResetRequest_r;
	logic insertionPolarity_r;
	logic activateRequest_r;
	logic activateStart_r;
	logic deactivateStart_r;
	user_card_pkg::clock_cfg_type clockCfg_r;
	user_card_pkg::supply_level_type supply_r;
	logic driveCard_r;
	logic driveHost_r;
	logic [2:0] blank_r;
	logic [7:0] statusVal;
	logic [7:0] settingsVal;
	logic [7:0] clockVal;
	logic [7:0] regRdata_r;

	function automatic logic stickyNext(input logic cur, input logic set,
		input logic clr);
		// Set beats a clear in the same cycle
		stickyNext = set | (cur & ~clr);
	endfunction

	function automatic user_card_pkg::supply_level_type supplyDecode(
		input logic [1:0] code);
		case (code)
			2'b10: supplyDecode = user_card_pkg::SUPPLY_3V0;
			2'b11: supplyDecode = user_card_pkg::SUPPLY_5V0;
			default: supplyDecode = user_card_pkg::SUPPLY_1V8;
		endcase
	endfunction

	// Asynchronous assert, synchronous release
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rstMeta_r <= 1'b0;
			rstSyncN <= 1'b0;
		end
		else
		begin
			rstMeta_r <= 1'b1;
			rstSyncN <= rstMeta_r;
		end
	end

	// Pins: {card data, host data, presence}; a change counts when
	// the second and third stages agree
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			sync1_r <= 3'h7;
			sync2_r <= 3'h7;
			sync3_r <= 3'h7;
			filt_r <= 3'h7;
		end
		else
		begin
			sync1_r <= {cardDataLineIn, hostDataLineIn, presencePin};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
		end
	end

	assign asyncMode = opMode == user_card_pkg::MODE_ASYNC;
	assign syncMode = opMode == user_card_pkg::MODE_SYNC1 ||
		opMode == user_card_pkg::MODE_SYNC2;
	assign statusRead = regRead && regAddr == `UC_STATUS_ADDR;
	assign settingsWrite = regWrite && regAddr == `UC_SETTINGS_ADDR;
	assign clockWrite = regWrite && regAddr == `UC_CLOCK_ADDR;

	assign cardPresentFlag = insertionPolarity_r ? filt_r[0] : ~filt_r[0];
	assign insertEdge = presenceReady_r && (filt_r[0] != presenceSeen_r);

	// Ready flag masks the first cycle after reset and each cycle after the stages disagree; a move of the filter off its reset value still counts
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			presenceSeen_r <= 1'b1;
			presenceReady_r <= 1'b0;
		end
		else
		begin
			presenceSeen_r <= filt_r[0];
			presenceReady_r <= sync2_r[0] == sync3_r[0];
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			answerTooSoonFlag <= 1'b0;
			answerMissingFlag <= 1'b0;
			overcurrentFlag <= 1'b0;
			insertChangeFlag <= 1'b0;
			supplyRampFaultFlag <= 1'b0;
		end
		else
		begin
			answerTooSoonFlag <= stickyNext(answerTooSoonFlag,
				cardEvents.answerTooSoon, statusRead);
			answerMissingFlag <= stickyNext(answerMissingFlag,
				cardEvents.answerMissing, statusRead);
			overcurrentFlag <= stickyNext(overcurrentFlag,
				cardEvents.overcurrent, statusRead);
			insertChangeFlag <= stickyNext(insertChangeFlag, insertEdge,
				statusRead);
			supplyRampFaultFlag <= stickyNext(supplyRampFaultFlag,
				cardEvents.supplyRampFault, statusRead);
		end
	end

	// Summary follows the sticky flags, so one status read clears it
	assign slotIrqSummary = answerTooSoonFlag | answerMissingFlag |
		overcurrentFlag | insertChangeFlag | supplyRampFaultFlag;

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			cardSupplySelect_r <= `SUPPLY_RESET;
			dataLineConnect_r <= `CONNECT_RESET;
			insertionPolarity_r <= `POLARITY_RESET;
		end
		else if (settingsWrite)
		begin
			cardSupplySelect_r <= regWdata[`SET_SUPPLY_HI:`SET_SUPPLY_LO];
			dataLineConnect_r <= regWdata[`SET_CONNECT_BIT];
			insertionPolarity_r <= regWdata[`SET_POLARITY_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			supply_r <= user_card_pkg::SUPPLY_1V8;
		else
			supply_r <= supplyDecode(cardSupplySelect_r);
	end

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			warmResetRequest_r <= `WARM_RESET;
		else if (warmResetStarted)
			warmResetRequest_r <= 1'b0;
		else if (settingsWrite && asyncMode && regWdata[`SET_WARM_BIT])
			warmResetRequest_r <= 1'b1;
	end

	// Automatic deactivation wins over a write in the same cycle
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			activateRequest_r <= `ACTIVATE_RESET;
			activateStart_r <= 1'b0;
			deactivateStart_r <= 1'b0;
		end
		else
		begin
			activateStart_r <= 1'b0;
			deactivateStart_r <= 1'b0;
			if (autoDeactivate)
				activateRequest_r <= 1'b0;
			else if (settingsWrite && asyncMode)
			begin
				activateRequest_r <= regWdata[`SET_ACTIVATE_BIT];
				activateStart_r <= regWdata[`SET_ACTIVATE_BIT] &
					~activateRequest_r;
				deactivateStart_r <= ~regWdata[`SET_ACTIVATE_BIT] &
					activateRequest_r;
			end
		end
	end

	assign seqCtrl.activateStart = activateStart_r;
	assign seqCtrl.deactivateStart = deactivateStart_r;
	assign seqCtrl.warmResetRequest = warmResetRequest_r;
	assign cardSupplySelect = supply_r;

	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			clockCfg_r.internalOscSelect <= `INT_OSC_RESET;
			clockCfg_r.clockForceLow <= `FORCE_LOW_RESET;
			clockCfg_r.clockForceHigh <= `FORCE_HIGH_RESET;
			clockCfg_r.clockDividerCode <= `DIV_RESET;
		end
		else if (clockWrite)
		begin
			clockCfg_r.internalOscSelect <= regWdata[`CLK_INT_OSC_BIT];
			clockCfg_r.clockForceLow <= regWdata[`CLK_LOW_BIT];
			clockCfg_r.clockForceHigh <= regWdata[`CLK_HIGH_BIT];
			clockCfg_r.clockDividerCode <= regWdata[`CLK_DIV_HI:`CLK_DIV_LO];
		end
	end

	card_clock_gen clockGen (
		.mclk(mclk),
		.rstSyncN(rstSyncN),
		.cfg(clockCfg_r),
		.syncMode(syncMode),
		.syncClockEnable(syncClockEnable),
		.cardClockOut(cardClockOut),
		.internalOscActive(internalOscActiveFlag)
	);

	// Open-drain repeater; the blanking gap stops our own pull-down
	// being seen through the synchronisers and echoed back
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			driveCard_r <= 1'b0;
			driveHost_r <= 1'b0;
			blank_r <= 3'h0;
		end
		else if (!dataLineConnect_r)
		begin
			driveCard_r <= 1'b0;
			driveHost_r <= 1'b0;
			blank_r <= 3'h0;
		end
		else if ((driveCard_r && filt_r[1]) || (driveHost_r && filt_r[2]))
		begin
			driveCard_r <= 1'b0;
			driveHost_r <= 1'b0;
			blank_r <= `DATA_BLANK_CYCLES;
		end
		else if (blank_r != 3'h0)
			blank_r <= blank_r - 3'h1;
		else if (!driveCard_r && !driveHost_r)
		begin
			driveCard_r <= ~filt_r[1];
			driveHost_r <= filt_r[1] & ~filt_r[2];
		end
	end

	assign cardDataLineOut = 1'b0;
	assign hostDataLineOut = 1'b0;
	assign cardDataLineOen_n = ~driveCard_r;
	assign hostDataLineOen_n = ~driveHost_r;

	always_comb
	begin
		statusVal = 8'h00;
		statusVal[`ST_POWERED_BIT] = slotPoweredFlag;
		statusVal[`ST_TOO_SOON_BIT] = answerTooSoonFlag;
		statusVal[`ST_MISSING_BIT] = answerMissingFlag;
		statusVal[`ST_OVERCURRENT_BIT] = overcurrentFlag;
		statusVal[`ST_INT_OSC_BIT] = internalOscActiveFlag;
		statusVal[`ST_INSERT_CHG_BIT] = insertChangeFlag;
		statusVal[`ST_PRESENT_BIT] = cardPresentFlag;
		statusVal[`ST_RAMP_FAULT_BIT] = supplyRampFaultFlag;
	end

	always_comb
	begin
		settingsVal = 8'h00;
		settingsVal[`SET_SUPPLY_HI:`SET_SUPPLY_LO] = cardSupplySelect_r;
		settingsVal[`SET_CONNECT_BIT] = dataLineConnect_r;
		settingsVal[`SET_WARM_BIT] = warmResetRequest_r;
		settingsVal[`SET_POLARITY_BIT] = insertionPolarity_r;
		settingsVal[`SET_ACTIVATE_BIT] = activateRequest_r;
		clockVal = 8'h00;
		clockVal[`CLK_INT_OSC_BIT] = clockCfg_r.internalOscSelect;
		clockVal[`CLK_LOW_BIT] = clockCfg_r.clockForceLow;
		clockVal[`CLK_HIGH_BIT] = clockCfg_r.clockForceHigh;
		clockVal[`CLK_DIV_HI:`CLK_DIV_LO] = clockCfg_r.clockDividerCode;
	end

	// Read data holds until the next read; unmapped reads return zero
	always_ff @(posedge mclk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			regRdata_r <= 8'h00;
		else if (regRead)
		begin
			case (regAddr)
				`UC_STATUS_ADDR: regRdata_r <= statusVal;
				`UC_SETTINGS_ADDR: regRdata_r <= settingsVal;
				`UC_CLOCK_ADDR: regRdata_r <= clockVal;
				default: regRdata_r <= 8'h00;
			endcase
		end
	end

	assign regRdata = regRdata_r;

endmodule

// >>> verification/card_model.sv
// Card seated in the user slot: presence switch and data line pull.
// Assumes the bench steers insertion and data-line pulls of the card.
module card_model (
	input wire logic cardPresent,
	input wire logic cardPull,
	input wire logic cardDataLineOen_n,
	output logic presencePin,
	output logic cardDataLineIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Switch grounds the pull-up pin when seated
	assign presencePin = !cardPresent;
	// Pull-up line: low if either end pulls
	assign cardDataLineIn = cardDataLineOen_n && !cardPull;
endmodule

// >>> verification/user_card_interface_regs_checker.sv
// Assertions on the user card slot register ports.
// Assumes binding to user_card_interface_regs, one clock domain.
module user_card_interface_regs_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire user_card_pkg::op_mode_type opMode,
	input wire logic slotPoweredFlag,
	input wire user_card_pkg::card_events_type cardEvents,
	input wire logic warmResetStarted,
	input wire logic cardClockOut,
	input wire user_card_pkg::seq_ctrl_type seqCtrl,
	input wire logic slotIrqSummary
);
	logic [1:0] rdyCnt_r;
	logic [7:0] clkCfg_r;
	logic syncM;
	logic oscExp;
	assign syncM = opMode == user_card_pkg::MODE_SYNC1 ||
		opMode == user_card_pkg::MODE_SYNC2;
	assign oscExp = clkCfg_r[7] && !syncM;
	// Design leaves reset two edges after rstn
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			rdyCnt_r <= 2'h0;
		else if (rdyCnt_r != 2'h3)
			rdyCnt_r <= rdyCnt_r + 2'h1;
	end
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			clkCfg_r <= 8'h0c;
		else if (regWrite && regAddr == 8'h02)
			clkCfg_r <= regWdata;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rdyCnt_r != 2'h3);
	sequence s_rd;
		regRead && regAddr == 8'h00 && cardEvents == 4'h0;
	endsequence
	sequence s_gap;
		!regRead && cardEvents == 4'h0;
	endsequence
	property p_powered;
		regRead && regAddr == 8'h00 && $stable(slotPoweredFlag)
		|=> regRdata[7] == $past(slotPoweredFlag);
	endproperty
	a_powered: assert property (p_powered) else $error("bit7 wrong");
	property p_soon;
		cardEvents.answerTooSoon |=> slotIrqSummary;
	endproperty
	a_soon: assert property (p_soon) else $error("no summary");
	property p_missing;
		cardEvents.answerMissing |=> slotIrqSummary;
	endproperty
	a_missing: assert property (p_missing) else $error("no summary");
	property p_overcur;
		cardEvents.overcurrent |=> slotIrqSummary;
	endproperty
	a_overcur: assert property (p_overcur) else $error("no summary");
	property p_ramp;
		cardEvents.supplyRampFault |=> slotIrqSummary;
	endproperty
	a_ramp: assert property (p_ramp) else $error("no summary");
	property p_clear;
		s_rd ##1 s_gap ##1 s_rd |=> (regRdata & 8'h71) == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("flag kept");
	property p_warm_no;
		regWrite && regAddr == 8'h01 && regWdata[3] &&
		opMode != user_card_pkg::MODE_ASYNC && !seqCtrl.warmResetRequest
		|=> !seqCtrl.warmResetRequest;
	endproperty
	a_warm_no: assert property (p_warm_no) else $error("warm taken");
	property p_warm_go;
		regWrite && regAddr == 8'h01 && regWdata[3] &&
		opMode == user_card_pkg::MODE_ASYNC && !warmResetStarted
		|=> seqCtrl.warmResetRequest;
	endproperty
	a_warm_go: assert property (p_warm_go) else $error("warm lost");
	property p_low;
		(clkCfg_r[6] && (!clkCfg_r[7] || syncM)) [*3] |-> !cardClockOut;
	endproperty
	a_low: assert property (p_low) else $error("clock not low");
	property p_osc;
		regRead && regAddr == 8'h00 && $stable(oscExp)
		|=> regRdata[3] == $past(oscExp);
	endproperty
	a_osc: assert property (p_osc) else $error("bit3 wrong");
endmodule

// >>> verification/user_card_interface_regs_tb_top.sv
// Self-checking bench for the user card slot registers.
// Assumes the card model and checker files are compiled before it.
module user_card_interface_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regWdata = 8'h00;
	user_card_pkg::op_mode_type opMode = user_card_pkg::MODE_ASYNC;
	logic syncClockEnable = 1'b0;
	logic slotPoweredFlag = 1'b0;
	user_card_pkg::card_events_type cardEvents = 4'h0;
	logic warmResetStarted = 1'b0;
	logic autoDeactivate = 1'b0;
	logic cardPresent = 1'b0;
	logic cardPull = 1'b0;
	logic hostPull = 1'b0;
	logic [7:0] regRdata;
	logic presencePin, hostDataLineIn, hostDataLineOut, hostDataLineOen_n;
	logic cardDataLineIn, cardDataLineOut, cardDataLineOen_n, cardClockOut;
	logic slotIrqSummary;
	user_card_pkg::supply_level_type cardSupplySelect;
	user_card_pkg::seq_ctrl_type seqCtrl;
	int err_total = 0;
	int checks_done = 0;
	int edgeCnt = 0;
	int cycles = 0;
	int divN [8] = '{1, 2, 4, 5, 8, 8, 8, 8};
	int stBit [4] = '{0, 4, 5, 6};
	user_card_pkg::supply_level_type supExp [4] = '{user_card_pkg::SUPPLY_1V8,
		user_card_pkg::SUPPLY_1V8, user_card_pkg::SUPPLY_3V0,
		user_card_pkg::SUPPLY_5V0};
	// Host side: pull-up, the design's pull and the bench's own pull
	assign hostDataLineIn = hostDataLineOen_n && !hostPull;
	user_card_interface_regs dut (
		.mclk(mclk),
		.rstn(rstn),
		.regAddr(regAddr),
		.regWrite(regWrite),
		.regRead(regRead),
		.regWdata(regWdata),
		.regRdata(regRdata),
		.opMode(opMode),
		.syncClockEnable(syncClockEnable),
		.slotPoweredFlag(slotPoweredFlag),
		.cardEvents(cardEvents),
		.warmResetStarted(warmResetStarted),
		.autoDeactivate(autoDeactivate),
		.presencePin(presencePin),
		.hostDataLineIn(hostDataLineIn),
		.hostDataLineOut(hostDataLineOut),
		.hostDataLineOen_n(hostDataLineOen_n),
		.cardDataLineIn(cardDataLineIn),
		.cardDataLineOut(cardDataLineOut),
		.cardDataLineOen_n(cardDataLineOen_n),
		.cardClockOut(cardClockOut),
		.cardSupplySelect(cardSupplySelect),
		.seqCtrl(seqCtrl),
		.slotIrqSummary(slotIrqSummary)
	);
	card_model card (.cardPresent(cardPresent), .cardPull(cardPull),
		.cardDataLineOen_n(cardDataLineOen_n), .presencePin(presencePin),
		.cardDataLineIn(cardDataLineIn));
	initial
	begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge cardClockOut) edgeCnt++;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			final_report();
		end
	end
	task final_report();
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge mclk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chk(regRdata & m, e);
	endtask
	// Edge count tolerates one edge of phase slop
	task clk_cnt(input int n, input int e);
		int s;
		int d;
		repeat (4) @(posedge mclk);
		s = edgeCnt;
		repeat (n) @(posedge mclk);
		d = edgeCnt - s - e;
		chk({7'h0, d >= -1 && d <= 1}, 8'h01);
	endtask
	// Stimulus outside the tasks always follows a clock edge
	initial
	begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (12) @(posedge mclk);
		rd(8'h00, 8'hff, 8'h00);
		rd(8'h01, 8'hff, 8'h60);
		rd(8'h02, 8'hff, 8'h0c);
		rd(8'h03, 8'hff, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h01, {i[1:0], 6'h20});
			@(posedge mclk);
			#1;
			chk({6'h0, cardSupplySelect}, {6'h0, supExp[i]});
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge mclk);
			cardEvents <= user_card_pkg::card_events_type'(4'h1 << i);
			@(posedge mclk);
			cardEvents <= 4'h0;
			#1;
			chk({7'h0, slotIrqSummary}, 8'h01);
			rd(8'h00, 8'h71, 8'h01 << stBit[i]);
			rd(8'h00, 8'h71, 8'h00);
			chk({7'h0, slotIrqSummary}, 8'h00);
		end
		@(posedge mclk);
		slotPoweredFlag <= 1'b1;
		rd(8'h00, 8'h80, 8'h80);
		@(posedge mclk);
		slotPoweredFlag <= 1'b0;
		rd(8'h00, 8'h80, 8'h00);
		@(posedge mclk);
		cardPresent <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(8'h00, 8'h06, 8'h06);
		rd(8'h00, 8'h06, 8'h02);
		wr(8'h01, 8'h64);
		rd(8'h00, 8'h02, 8'h00);
		@(posedge mclk);
		cardPresent <= 1'b0;
		repeat (10) @(posedge mclk);
		rd(8'h00, 8'h06, 8'h06);
		wr(8'h01, 8'h61);
		#1;
		chk({7'h0, seqCtrl.activateStart}, 8'h01);
		@(posedge mclk);
		autoDeactivate <= 1'b1;
		@(posedge mclk);
		autoDeactivate <= 1'b0;
		rd(8'h01, 8'h01, 8'h00);
		wr(8'h01, 8'h61);
		wr(8'h01, 8'h60);
		#1;
		chk({7'h0, seqCtrl.deactivateStart}, 8'h01);
		wr(8'h01, 8'h68);
		#1;
		chk({7'h0, seqCtrl.warmResetRequest}, 8'h01);
		@(posedge mclk);
		warmResetStarted <= 1'b1;
		@(posedge mclk);
		warmResetStarted <= 1'b0;
		#1;
		chk({7'h0, seqCtrl.warmResetRequest}, 8'h00);
		@(posedge mclk);
		opMode <= user_card_pkg::MODE_SYNC1;
		wr(8'h01, 8'h49);
		rd(8'h01, 8'h29, 8'h00);
		@(posedge mclk);
		opMode <= user_card_pkg::MODE_MANUAL;
		wr(8'h01, 8'h69);
		rd(8'h01, 8'h09, 8'h00);
		@(posedge mclk);
		opMode <= user_card_pkg::MODE_ASYNC;
		for (int c = 0; c < 2; c++)
		begin
			wr(8'h01, c ? 8'h60 : 8'h40);
			cardPull <= 1'b1;
			repeat (10) @(posedge mclk);
			chk({7'h0, hostDataLineOen_n}, c ? 8'h00 : 8'h01);
			cardPull <= 1'b0;
			repeat (12) @(posedge mclk);
			hostPull <= 1'b1;
			repeat (10) @(posedge mclk);
			chk({7'h0, cardDataLineOen_n}, c ? 8'h00 : 8'h01);
			hostPull <= 1'b0;
			repeat (12) @(posedge mclk);
		end
		chk({6'h0, cardDataLineOut, hostDataLineOut}, 8'h00);
		wr(8'h02, 8'h40);
		clk_cnt(80, 0);
		wr(8'h02, 8'h20);
		clk_cnt(80, 0);
		chk({7'h0, cardClockOut}, 8'h01);
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h02, {3'h0, k[2:0], 2'h0});
			clk_cnt(80, 80 / divN[k]);
		end
		wr(8'h02, 8'hc0);
		clk_cnt(520, 5);
		rd(8'h00, 8'h08, 8'h08);
		@(posedge mclk);
		opMode <= user_card_pkg::MODE_SYNC2;
		syncClockEnable <= 1'b1;
		clk_cnt(80, 0);
		wr(8'h02, 8'h94);
		clk_cnt(80, 80);
		rd(8'h00, 8'h08, 8'h00);
		@(posedge mclk);
		syncClockEnable <= 1'b0;
		wr(8'h02, 8'h20);
		clk_cnt(80, 0);
		chk({7'h0, cardClockOut}, 8'h01);
		// Second reset in mid-run must restore the documented values
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(8'h00, 8'hff, 8'h00);
		rd(8'h01, 8'hff, 8'h60);
		rd(8'h02, 8'hff, 8'h0c);
		final_report();
	end
endmodule
bind user_card_interface_regs user_card_interface_regs_checker chk (
	.mclk(mclk),
	.rstn(rstn),
	.regAddr(regAddr),
	.regWrite(regWrite),
	.regRead(regRead),
	.regWdata(regWdata),
	.regRdata(regRdata),
	.opMode(opMode),
	.slotPoweredFlag(slotPoweredFlag),
	.cardEvents(cardEvents),
	.warmResetStarted(warmResetStarted),
	.cardClockOut(cardClockOut),
	.seqCtrl(seqCtrl),
	.slotIrqSummary(slotIrqSummary)
);
